// ### logic/rfl_defines.svh
// Constants shared by both ends of the radio FIFO link.
// Assumes inclusion by bare name from files under logic/ and tb/.
`ifndef RFL_DEFINES_SVH
`define RFL_DEFINES_SVH

// ==========================================================
// Device register addresses (7-bit SPI address field)
`define RFL_A_CFG     7'h00
`define RFL_A_TXSA    7'h01
`define RFL_A_TXLEN   7'h02
`define RFL_A_RXLEN   7'h03
`define RFL_A_ARK     7'h04
`define RFL_A_AWIN    7'h05
`define RFL_A_RDLY    7'h06
`define RFL_A_GIO1    7'h07
`define RFL_A_STAT    7'h0A
`define RFL_A_FIFO    7'h0B
`define RFL_A_TXLVL   7'h0C
`define RFL_A_S_TXR   7'h10
`define RFL_A_S_RXR   7'h11
`define RFL_A_S_TX    7'h12
`define RFL_A_S_RX    7'h13
`define RFL_A_S_SLP   7'h14

// ==========================================================
// Field positions
`define RFL_C_MEN     0
`define RFL_C_MSEL    1
`define RFL_C_LTIE    3
`define RFL_C_UNB     4
`define RFL_C_CONT    5
`define RFL_C_L2F     6
`define RFL_C_LF      7
`define RFL_K_EN      0
`define RFL_K_LIM     4
`define RFL_F_TXD     0
`define RFL_F_RXD     1
`define RFL_F_LT      2
`define RFL_F_ERR     3

// ==========================================================
// Reset values and codes
`define RFL_REG_RST   8'h00
`define RFL_GIO_RST   3'h0
`define RFL_GIO_IRQ   3'h5
`define RFL_FIFO_FULL 7'h40
`define RFL_MARGIN_LO 7'h04

// ==========================================================
// Timing
`define RFL_CLK_MHZ   200
`define RFL_UNIT_US   250
`define RFL_UNIT_CYC  (`RFL_UNIT_US * `RFL_CLK_MHZ)
`define RFL_SCK_HALF  6

// ==========================================================
// Host command port addresses
`define RFL_H_CMD     2'h0
`define RFL_H_STAT    2'h1
`define RFL_H_RDATA   2'h2

`endif

// ### logic/rfl_pkg.sv
// Types shared by both ends of the radio FIFO link.
// Assumes nothing beyond a SystemVerilog compiler.
package rfl_pkg;

  // ==========================================================
  // Device link-layer states
  typedef enum logic [2:0]
  {
    ST_SLEEP = 3'h0,
    ST_TX    = 3'h1,
    ST_ACKW  = 3'h3,
    ST_GAP   = 3'h2,
    ST_RX    = 3'h6,
    ST_ACKTX = 3'h7
  } rfl_state_e;

  // ==========================================================
  // Host serial engine states
  typedef enum logic [1:0]
  {
    HS_IDLE = 2'h0,
    HS_LO   = 2'h1,
    HS_HI   = 2'h3,
    HS_END  = 2'h2
  } rfl_hstate_e;

endpackage

// ### logic/rfl_if.sv
// Four-wire serial link plus general pins between host and radio.
// Assumes the bench instantiates it and hands one modport to each end.
`timescale 1ns/1ps
interface rfl_if;
  logic       sclk;   // Serial clock, made by host
  logic       csn_b;  // Frame select, active low
  logic       mosi;   // Host to device data
  logic       miso;   // Device to host data
  logic [2:0] gio;    // General pins from device

  // ==========================================================
  // Party views
  modport dev  (input sclk, csn_b, mosi, output miso, gio);
  modport host (output sclk, csn_b, mosi, input miso, gio);
endinterface

// ### logic/rfl_device.sv
// Radio FIFO and link-layer controller, device end of the link.
// Assumes a modem on the user side clocked by ref_clk, host on rfl_if.
// Summary of operation
// RULE1: Host resets FIFOs, loads lengths, then strobes.
// RULE2: Resend rewinds transmit read pointer to start.
// RULE3: End of TX or RX raises completion flag.
// RULE4: Block mode sends length bytes from start address.
// RULE5: Extended mode moves 255 bytes through 64.
// RULE6: Margin select picks 4/8/16/32 when enabled.
// RULE7: Low level in TX sets low threshold flag.
// RULE8: Empty transmit FIFO ends the transmission.
// RULE9: Host refills at most 64 minus threshold.
// RULE10: Function code 101b puts interrupt on pin.
// RULE11: RX fill raises low threshold; host drains.
// RULE12: Unbounded TX ends after reloaded remaining length.
// RULE13: Unbounded RX ends after reloaded remaining length.
// RULE14: Continuous RX relistens after delay; invalid silent.
// RULE15: Sleep strobe stops; continuous only simple mode.
// RULE16: Length byte stored in FIFO when enabled.
// RULE17: Receive overflow sets error flag and interrupt.
// RULE18: After TX, await acknowledge window plus one.
// RULE19: Good acknowledge completes; else bounded resends.
// RULE20: Keep last tag and CRC; match means repeat.
// RULE21: New acked with flag, repeat silent, bad restarts.
// RULE22: Wait window period after reception before relisten.
// RULE23: Flag holds until cleared; interrupt follows flag.
`timescale 1ns/1ps
`include "rfl_defines.svh"
module rfl_device
  import rfl_pkg::*;
#(
  parameter int UNIT_CYC = `RFL_UNIT_CYC  // Cycles in one 250 us unit
)(
  input  wire logic        ref_clk,    // System clock
  input  wire logic        rst_b,      // Async reset, active low
  rfl_if.dev               lnk,        // Serial link to host
  output logic [7:0]       tx_data,    // Byte to modem
  output logic             tx_valid,   // Byte offered
  output logic             tx_last,    // Final byte of packet
  input  wire logic        tx_ready,   // Modem takes byte
  input  wire logic        rx_valid,   // Byte from modem
  input  wire logic [7:0]  rx_data,    // Received byte
  input  wire logic        rx_crc_ok,  // CRC good, with last byte
  input  wire logic        rx_addr_ok, // Address good, with last byte
  input  wire logic [1:0]  rx_tag,     // Sequence tag, with last byte
  input  wire logic [15:0] rx_crc,     // Packet CRC, with last byte
  input  wire logic        ack_ok,     // Valid acknowledge heard
  output logic             ack_send,   // Send acknowledge, pulse
  input  wire logic        ack_done,   // Acknowledge sent, pulse
  output logic             irq         // Interrupt request level
);

  if (UNIT_CYC < 1 || UNIT_CYC > 65536)
    $error("UNIT_CYC must be 1 to 65536");
  localparam logic [15:0] PRE_LD = 16'(UNIT_CYC - 1);

  // ==========================================================
  // Declarations
  rfl_state_e  st_q, st_d;
  logic [2:0]  sck_r, csn_r;
  logic [1:0]  mosi_r;
  logic [4:0]  bit_q;
  logic [15:0] sh_q;
  logic [7:0]  out_q;
  logic        miso_q;
  logic [7:0]  cfg_q, tlen_q, rlen_q, ark_q, awin_q, cnt_q, rtgt_q;
  logic [5:0]  tsa_q;
  logic [2:0]  rdly_q;
  logic [2:0]  gsel_q [3];
  logic [3:0]  flg_q;
  logic [7:0]  txm [64];
  logic [7:0]  rxm [64];
  logic [6:0]  twp_q, trp_q, rwp_q, rrp_q;
  logic [4:0]  rsn_q;
  logic [15:0] pre_q;
  logic [8:0]  unit_q, t_u;
  logic [1:0]  tag_q;
  logic [15:0] crc_q;
  logic        seen_q, hdr_q;
  logic        t_ld, tx_set, rx_set, tx_arm, rx_arm, ack_go;

  // ==========================================================
  // Link pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_r  <= 3'h0;
      csn_r  <= 3'h7;
      mosi_r <= 2'h0;
    end
    else
    begin
      sck_r  <= {sck_r[1:0], lnk.sclk};
      csn_r  <= {csn_r[1:0], lnk.csn_b};
      mosi_r <= {mosi_r[0], lnk.mosi};
    end
  end

  // Frame decode: byte 0 is {write, address}, byte 1 is data
  wire        cs_on   = ~csn_r[1];
  wire        sck_up  = cs_on & sck_r[1] & ~sck_r[2];
  wire        sck_dn  = cs_on & ~sck_r[1] & sck_r[2];
  wire [15:0] sh_n    = {sh_q[14:0], mosi_r[1]};
  wire        cmd_end = sck_up & (bit_q == 5'h07);
  wire        rd_req  = cmd_end & ~sh_n[7];
  wire [6:0]  ra      = sh_n[6:0];
  wire        wr      = sck_up & (bit_q == 5'h0F) & sh_n[15];
  wire [6:0]  wa      = sh_n[14:8];
  wire [7:0]  wd      = sh_n[7:0];

  // Strobes are writes to their own addresses; data ignored
  wire s_txr = wr & (wa == `RFL_A_S_TXR);
  wire s_rxr = wr & (wa == `RFL_A_S_RXR);
  wire s_tx  = wr & (wa == `RFL_A_S_TX);
  wire s_rx  = wr & (wa == `RFL_A_S_RX);
  wire s_slp = wr & (wa == `RFL_A_S_SLP);

  // Configuration views
  wire       men  = cfg_q[`RFL_C_MEN];
  wire       unb  = cfg_q[`RFL_C_UNB];
  wire       lf   = cfg_q[`RFL_C_LF];
  wire       l2f  = cfg_q[`RFL_C_L2F] & lf;  // RULE16
  wire       ark  = ark_q[`RFL_K_EN];
  wire       cont = cfg_q[`RFL_C_CONT] & ~unb & ~ark;  // RULE15
  wire [6:0] mval = `RFL_MARGIN_LO << cfg_q[`RFL_C_MSEL +: 2];  // RULE6

  // FIFO levels are 7 bits so a full 64 differs from empty
  wire [6:0] tlvl = twp_q - trp_q;  // RULE5
  wire [6:0] rlvl = rwp_q - rrp_q;
  wire [7:0] cnt_n = cnt_q + 8'h01;

  // Transmit side toward the modem
  assign tx_valid = (st_q == ST_TX) & (tlvl != 7'h00);
  assign tx_data  = txm[trp_q[5:0]];
  assign tx_last  = ~unb & (cnt_n == tlen_q);  // RULE4 RULE12
  wire   tx_hs    = tx_valid & tx_ready;
  wire   tx_push  = wr & (wa == `RFL_A_FIFO) & (tlvl != `RFL_FIFO_FULL);

  // Receive side from the modem; optional length byte leads
  wire       rx_in  = (st_q == ST_RX) & rx_valid;
  wire       len_b  = rx_in & hdr_q;
  wire       pay_b  = rx_in & ~hdr_q;
  wire [7:0] rtgt   = lf ? rtgt_q : rlen_q;
  wire       rx_fin = pay_b & ~unb & (cnt_n == rtgt);  // RULE13
  wire       rx_psh = pay_b | (len_b & l2f);  // RULE16
  wire       rx_ovf = rx_psh & (rlvl == `RFL_FIFO_FULL);  // RULE17
  wire       rx_pop = rd_req & (ra == `RFL_A_FIFO) & (rlvl != 7'h00);
  wire       pkt_ok = rx_crc_ok & rx_addr_ok;
  wire       rep    = seen_q & (rx_tag == tag_q) & (rx_crc == crc_q);  // RULE20

  // Threshold watch; the host refill keeps the level up
  wire lt_tx  = (st_q == ST_TX) & (tlvl < mval);  // RULE7 RULE9
  wire lt_rx  = (st_q == ST_RX) & (rlvl >= `RFL_FIFO_FULL - mval);  // RULE11
  wire lt_set = men & (lt_tx | lt_rx);

  // Timer expiry in whole units; zero units expire at once
  wire tmo    = (unit_q == 9'h000) | ((unit_q == 9'h001) & (pre_q == 16'h0000));
  wire rsn_ok = rsn_q < ({1'b0, ark_q[`RFL_K_LIM +: 4]} + 5'h01);  // RULE19

  // Flags: hardware set wins over a host clear in the same cycle
  wire [3:0] f_clr = (wr & (wa == `RFL_A_STAT)) ? wd[3:0] : 4'h0;
  wire [3:0] f_set = {rx_ovf, lt_set, rx_set, tx_set};
  wire [3:0] f_d   = (flg_q & ~f_clr) | f_set;  // RULE23
  wire [3:0] f_en  = {1'b1, cfg_q[`RFL_C_LTIE], 2'h3};
  assign irq      = |(flg_q & f_en);  // RULE3 RULE23
  assign ack_send = ack_go;

  // Read data mux
  wire [7:0] rd_data =
    (ra == `RFL_A_CFG)   ? cfg_q :
    (ra == `RFL_A_TXSA)  ? {2'h0, tsa_q} :
    (ra == `RFL_A_TXLEN) ? tlen_q :
    (ra == `RFL_A_RXLEN) ? rlen_q :
    (ra == `RFL_A_ARK)   ? ark_q :
    (ra == `RFL_A_AWIN)  ? awin_q :
    (ra == `RFL_A_RDLY)  ? {5'h00, rdly_q} :
    (ra == `RFL_A_STAT)  ? {1'b0, st_q, flg_q} :
    (ra == `RFL_A_FIFO)  ? rxm[rrp_q[5:0]] :
    (ra == `RFL_A_TXLVL) ? {1'b0, tlvl} : 8'h00;

  // ==========================================================
  // Link-layer state machine
  always_comb
  begin
    st_d = st_q;
    t_ld = 1'b0;
    t_u = 9'h000;
    tx_set = 1'b0;
    rx_set = 1'b0;
    tx_arm = 1'b0;
    rx_arm = 1'b0;
    ack_go = 1'b0;
    unique case (st_q)
      ST_SLEEP:
        if (s_tx)
        begin
          st_d = ST_TX;
          tx_arm = 1'b1;
        end
        else if (s_rx)
        begin
          st_d = ST_RX;
          rx_arm = 1'b1;
        end
      ST_TX:
        if (tx_hs & tx_last)
        begin
          if (ark)
          begin
            st_d = ST_ACKW;
            t_ld = 1'b1;
            t_u = {1'b0, awin_q} + 9'h001;  // RULE18
          end
          else
          begin
            st_d = ST_SLEEP;
            tx_set = 1'b1;  // RULE3
          end
        end
        else if (tlvl == 7'h00)
        begin
          st_d = ST_SLEEP;  // RULE8
          tx_set = 1'b1;
        end
      ST_ACKW:
        if (ack_ok)
        begin
          st_d = ST_SLEEP;
          tx_set = 1'b1;  // RULE19
        end
        else if (tmo)
        begin
          st_d = rsn_ok ? ST_TX : ST_SLEEP;
          tx_arm = rsn_ok;  // RULE19
        end
      ST_RX:
        if (rx_fin)
        begin
          if (ark)
          begin
            st_d = pkt_ok ? ST_ACKTX : ST_RX;  // RULE21
            ack_go = pkt_ok;
            rx_set = pkt_ok & ~rep;
            rx_arm = ~pkt_ok;
          end
          else if (cont)
          begin
            st_d = ST_GAP;  // RULE14
            rx_set = pkt_ok;
            t_ld = 1'b1;
            t_u = {6'h00, rdly_q};
          end
          else
          begin
            st_d = ST_SLEEP;
            rx_set = 1'b1;  // RULE3
          end
        end
      ST_ACKTX:
        if (ack_done)
        begin
          st_d = ST_GAP;  // RULE22
          t_ld = 1'b1;
          t_u = {1'b0, awin_q};
        end
      ST_GAP:
        if (tmo)
        begin
          st_d = ST_RX;
          rx_arm = 1'b1;
        end
      default:
        st_d = ST_SLEEP;
    endcase
    if (s_slp)
    begin
      st_d = ST_SLEEP;  // RULE15
      tx_arm = 1'b0;
      rx_arm = 1'b0;
      ack_go = 1'b0;
    end
  end

  // ==========================================================
  // Serial shifter and reply byte
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_q <= 5'h00;
      sh_q <= 16'h0000;
      out_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else
    begin
      if (!cs_on)
        bit_q <= 5'h00;
      else if (sck_up)
      begin
        bit_q <= bit_q + 5'h01;
        sh_q <= sh_n;
      end
      // First reply bit goes out on the eighth rising edge and holds past the next fall
      if (cmd_end)
      begin
        miso_q <= rd_req & rd_data[7];
        out_q <= rd_req ? {rd_data[6:0], 1'b0} : 8'h00;
      end
      else if (sck_dn & (bit_q >= 5'h09))
      begin
        miso_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end
  assign lnk.miso = miso_q;

  // ==========================================================
  // Software registers and state
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q <= `RFL_REG_RST;
      tsa_q <= 6'h00;
      tlen_q <= `RFL_REG_RST;
      rlen_q <= `RFL_REG_RST;
      ark_q <= `RFL_REG_RST;
      awin_q <= `RFL_REG_RST;
      rdly_q <= 3'h0;
      flg_q <= 4'h0;
      st_q <= ST_SLEEP;
    end
    else
    begin
      if (wr & (wa == `RFL_A_CFG))   cfg_q <= wd;
      if (wr & (wa == `RFL_A_TXSA))  tsa_q <= wd[5:0];
      if (wr & (wa == `RFL_A_TXLEN)) tlen_q <= wd;
      if (wr & (wa == `RFL_A_RXLEN)) rlen_q <= wd;
      if (wr & (wa == `RFL_A_ARK))   ark_q <= wd;
      if (wr & (wa == `RFL_A_AWIN))  awin_q <= wd;
      if (wr & (wa == `RFL_A_RDLY))  rdly_q <= wd[2:0];
      flg_q <= f_d;
      st_q <= st_d;
    end
  end

  // General pins: function code selects the interrupt line
  for (genvar i = 0; i < 3; i++)
  begin : g_gio
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        gsel_q[i] <= `RFL_GIO_RST;
      else if (wr & (wa == 7'(`RFL_A_GIO1 + i)))
        gsel_q[i] <= wd[2:0];
    end
    assign lnk.gio[i] = (gsel_q[i] == `RFL_GIO_IRQ) & irq;  // RULE10
  end

  // ==========================================================
  // FIFO pointers, counters, timer, acknowledge memory
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      twp_q <= 7'h00;
      trp_q <= 7'h00;
      rwp_q <= 7'h00;
      rrp_q <= 7'h00;
      cnt_q <= 8'h00;
      rtgt_q <= 8'h00;
      hdr_q <= 1'b0;
      rsn_q <= 5'h00;
      pre_q <= 16'h0000;
      unit_q <= 9'h000;
      tag_q <= 2'h0;
      crc_q <= 16'h0000;
      seen_q <= 1'b0;
    end
    else
    begin
      if (s_txr)
        twp_q <= 7'h00;  // RULE1
      else if (tx_push)
        twp_q <= twp_q + 7'h01;
      // Read pointer restarts at the start address; wrap bit keeps level
      if (s_txr)
        trp_q <= 7'h00;
      else if (tx_arm)
        trp_q <= {twp_q[6] ^ (tsa_q >= twp_q[5:0]), tsa_q};  // RULE2 RULE4
      else if (tx_hs)
        trp_q <= trp_q + 7'h01;
      if (s_rxr)
        rwp_q <= 7'h00;
      else if (rx_psh & ~rx_ovf)
        rwp_q <= rwp_q + 7'h01;
      if (s_rxr)
        rrp_q <= 7'h00;
      else if (rx_pop)
        rrp_q <= rrp_q + 7'h01;
      // Unbounded mode clears the count so the reload counts the rest
      if (tx_arm | rx_arm | unb)
        cnt_q <= 8'h00;  // RULE12 RULE13
      else if (tx_hs | pay_b)
        cnt_q <= cnt_n;
      if (rx_arm)
        hdr_q <= lf;
      else if (len_b)
      begin
        hdr_q <= 1'b0;
        rtgt_q <= rx_data;
      end
      if (tx_arm)
        rsn_q <= (st_q == ST_ACKW) ? rsn_q + 5'h01 : 5'h00;  // RULE19
      if (t_ld)
      begin
        unit_q <= t_u;
        pre_q <= PRE_LD;
      end
      else if (unit_q != 9'h000)
      begin
        pre_q <= (pre_q == 16'h0000) ? PRE_LD : pre_q - 16'h0001;
        if (pre_q == 16'h0000)
          unit_q <= unit_q - 9'h001;
      end
      if (ack_go)
      begin
        tag_q <= rx_tag;  // RULE20
        crc_q <= rx_crc;
        seen_q <= 1'b1;
      end
    end
  end

  // FIFO storage needs no reset
  always_ff @(posedge ref_clk)
  begin
    if (tx_push)
      txm[twp_q[5:0]] <= wd;
    if (rx_psh & ~rx_ovf)
      rxm[rwp_q[5:0]] <= rx_data;
  end

endmodule

// ### logic/rfl_host.sv
// Host end: serial master driving the device registers and strobes.
// Assumes software sequences commands through the plain register port.
`timescale 1ns/1ps
`include "rfl_defines.svh"
module rfl_host
  import rfl_pkg::*;
#(
  parameter int SCK_HALF = `RFL_SCK_HALF  // Cycles per serial clock half
)(
  input  wire logic        ref_clk, // System clock
  input  wire logic        rst_b,   // Async reset, active low
  rfl_if.host              lnk,     // Serial link to device
  input  wire logic [1:0]  addr,    // Register address
  input  wire logic [15:0] wdata,   // Write data
  input  wire logic        wr,      // Write strobe
  input  wire logic        rd,      // Read strobe
  output logic [15:0]      rdata    // Read data, cycle after rd
);

  if (SCK_HALF < 4 || SCK_HALF > 256)
    $error("SCK_HALF must be 4 to 256");
  localparam logic [7:0] HALF_LD = 8'(SCK_HALF - 1);

  // ==========================================================
  // Declarations
  rfl_hstate_e hs_q;
  logic [7:0]  cnt_q, rx_q;
  logic [3:0]  bit_q;
  logic [15:0] sh_q;
  logic        sclk_q, csn_q, mosi_q;
  logic [1:0]  miso_r;
  logic [2:0]  gio_m, gio_s;

  // A frame is {write, address, data}; busy frames refuse new ones
  wire busy  = (hs_q != HS_IDLE);
  wire start = wr & (addr == `RFL_H_CMD) & ~busy;  // RULE1 RULE9
  wire half  = (cnt_q == 8'h00);
  wire [15:0] rmux =
    (addr == `RFL_H_STAT)  ? {12'h000, gio_s, busy} :
    (addr == `RFL_H_RDATA) ? {8'h00, rx_q} : 16'h0000;

  assign lnk.sclk  = sclk_q;
  assign lnk.csn_b = csn_q;
  assign lnk.mosi  = mosi_q;

  // ==========================================================
  // Pin synchronisers; interrupt pins let software pace refills
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      miso_r <= 2'h0;
      gio_m <= 3'h0;
      gio_s <= 3'h0;
    end
    else
    begin
      miso_r <= {miso_r[0], lnk.miso};
      gio_m <= lnk.gio;
      gio_s <= gio_m;  // RULE11 RULE17 RULE22
    end
  end

  // ==========================================================
  // Serial engine; reply bits sampled just before each fall
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hs_q <= HS_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sh_q <= 16'h0000;
      rx_q <= 8'h00;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      mosi_q <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      rdata <= rd ? rmux : 16'h0000;
      cnt_q <= (start | half) ? HALF_LD : cnt_q - 8'h01;
      unique case (hs_q)
        HS_IDLE:
          if (start)
          begin
            hs_q <= HS_LO;
            sh_q <= wdata;  // RULE12 RULE13
            mosi_q <= wdata[15];
            csn_q <= 1'b0;
            bit_q <= 4'h0;
          end
        HS_LO:
          if (half)
          begin
            hs_q <= HS_HI;
            sclk_q <= 1'b1;
          end
        HS_HI:
          if (half)
          begin
            sclk_q <= 1'b0;
            rx_q <= {rx_q[6:0], miso_r[1]};
            if (bit_q == 4'hF)
              hs_q <= HS_END;
            else
            begin
              hs_q <= HS_LO;
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[14:0], 1'b0};
              mosi_q <= sh_q[14];
            end
          end
        HS_END:
          // Select stays low one half, then high one half
          if (half)
          begin
            if (csn_q)
              hs_q <= HS_IDLE;
            csn_q <= 1'b1;
          end
      endcase
    end
  end

endmodule

// ### tb/rfl_link_chk.sv
// Assertions on the serial wires between host and device.
// Assumes the bench wires it beside the link, host SCK_HALF of 6.
`timescale 1ns/1ps
module rfl_link_chk (
  input wire logic       ref_clk, // System clock
  input wire logic       rst_b,   // Reset, active low
  input wire logic       sclk,    // Serial clock
  input wire logic       csn_b,   // Frame select, active low
  input wire logic       mosi,    // Host data
  input wire logic       miso,    // Device data, not judged
  input wire logic [2:0] gio      // General pins, not judged
);
  // ========
  // Rise counter; cleared between frames so a short frame shows
  logic       sclk_q;
  logic [4:0] rise_q;
  logic [4:0] rise_d;
  assign rise_d = csn_b ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      {sclk_q, rise_q} <= 6'h00;
    else
      {sclk_q, rise_q} <= {sclk, rise_d};

  // ========
  // Framing properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_high;
    sclk [*6] ##1 !sclk;
  endsequence
  sequence s_low;
    !sclk [*6];
  endsequence
  a_idle_low: assert property (csn_b |-> !sclk)
    else $error("serial clock high outside a frame");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_high_half: assert property ($rose(sclk) |-> s_high)
    else $error("clock high half has wrong length");
  a_low_half: assert property ($fell(sclk) |-> s_low)
    else $error("clock low half too short");
  a_first_wait: assert property ($fell(csn_b) |-> s_low)
    else $error("clock rose too soon after select");
  a_frame_bits: assert property ($rose(csn_b) |-> rise_q == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_frame_len: assert property ($fell(csn_b) |-> ##[190:230] $rose(csn_b))
    else $error("frame length out of range");
  a_frame_gap: assert property ($rose(csn_b) |-> csn_b [*6])
    else $error("frames too close together");
endmodule

// ### tb/radio_fifo_link_controller_test.sv
// Bench joining host and device ends; modem side driven here.
// Assumes package, interface and both ends compiled before it.
`timescale 1ns/1ps
`include "rfl_defines.svh"
module radio_fifo_link_controller_test
  import rfl_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tx_ready = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_crc_ok = 1'b0;
  logic        ack_done = 1'b0;
  logic [15:0] rdata;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        ack_send;
  logic        irq;
  logic [7:0]  b;
  logic [8:0]  txq[$];
  logic [7:0]  cfg_row[5] = '{8'h09, 8'h0B, 8'h0D, 8'h0F, 8'h0E};
  logic [7:0]  exp_row[5] = '{8'h10, 8'h10, 8'h14, 8'h14, 8'h10};
  int          failures = 0;
  int          samples_checked = 0;
  rfl_if lnk ();
  rfl_host u_rfl_host (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rfl_device #(.UNIT_CYC(20)) u_rfl_device (.ref_clk(ref_clk), .rst_b(rst_b),
    .lnk(lnk.dev), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_crc_ok(rx_crc_ok),
    .rx_addr_ok(1'b1), .rx_tag(2'h0), .rx_crc(16'h0000), .ack_ok(1'b0),
    .ack_send(ack_send), .ack_done(ack_done), .irq(irq));
  rfl_link_chk u_rfl_link_chk (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(lnk.sclk),
    .csn_b(lnk.csn_b), .mosi(lnk.mosi), .miso(lnk.miso), .gio(lnk.gio));

  // ========
  // Clock, watchdog and modem byte capture
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end
  always @(posedge ref_clk)
    if (tx_valid === 1'b1 && tx_ready)
      txq.push_back({tx_last, tx_data});
  always @(posedge ref_clk)
    ack_done <= ack_send;

  // ========
  // Compare, register port and device frame helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd_port(input logic [1:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Polls busy under a bound; a refused frame would be lost silently
  task automatic cmd(input logic [15:0] c);
    logic [15:0] v;
    @(posedge ref_clk);
    addr <= 2'h0;
    wdata <= c;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    v = 16'h0001;
    for (int n = 0; n < 300 && v[0] !== 1'b0; n++)
      rd_port(2'h1, v);
    chk("busy", 8'h00, {7'h00, v[0]});
  endtask
  task automatic dw(input logic [6:0] a, input logic [7:0] d);
    cmd({1'b1, a, d});
  endtask
  task automatic drd(input logic [6:0] a);
    logic [15:0] v;
    cmd({1'b0, a, 8'h00});
    rd_port(2'h2, v);
    b = v[7:0];
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ========
  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    drd(`RFL_A_STAT);
    chk("stat rst", 8'h00, b);
    dw(`RFL_A_TXLVL, 8'hFF);
    drd(`RFL_A_TXLVL);
    chk("lvl ro", 8'h00, b);
    $display("done: reset");
    // Eight bytes held, modem stalled; 8 sits on a margin boundary
    dw(`RFL_A_S_TXR, 8'h00);
    for (int i = 0; i < 8; i++)
      dw(`RFL_A_FIFO, 8'hB0 + 8'(i));
    dw(`RFL_A_TXLEN, 8'h0A);
    drd(`RFL_A_TXLVL);
    chk("level", 8'h08, b);
    for (int r = 0; r < 5; r++)
    begin
      dw(`RFL_A_CFG, cfg_row[r]);
      dw(`RFL_A_S_TX, 8'h00);
      drd(`RFL_A_STAT);
      chk("margin", exp_row[r], b);
      chk("irq", {7'h00, exp_row[r][2]}, {7'h00, irq});
      dw(`RFL_A_S_SLP, 8'h00);
      dw(`RFL_A_STAT, 8'hFF);
    end
    dw(`RFL_A_CFG, 8'h09);
    @(posedge ref_clk);
    tx_ready <= 1'b1;
    dw(`RFL_A_S_TX, 8'h00);
    drd(`RFL_A_STAT);
    chk("drain", 8'h05, b);
    chk("count", 8'h08, 8'(txq.size()));
    chk("first", 8'hB0, txq[0][7:0]);
    $display("done: margin");
    // Block start at byte 1, then a resend of the same packet
    dw(`RFL_A_CFG, 8'h00);
    dw(`RFL_A_S_TXR, 8'h00);
    for (int i = 0; i < 4; i++)
      dw(`RFL_A_FIFO, 8'hA0 + 8'(i));
    dw(`RFL_A_TXSA, 8'h01);
    dw(`RFL_A_TXLEN, 8'h02);
    dw(`RFL_A_GIO1, 8'h05);
    dw(`RFL_A_STAT, 8'hFF);
    for (int k = 0; k < 2; k++)
    begin
      txq.delete();
      dw(`RFL_A_S_TX, 8'h00);
      repeat (10) @(posedge ref_clk);
      chk("start", 8'hA1, txq[0][7:0]);
      chk("last", 8'h01, {7'h00, txq[1][8]});
      chk("gio", 8'h01, {5'h00, lnk.gio});
      drd(`RFL_A_STAT);
      chk("done", 8'h01, b);
      dw(`RFL_A_STAT, 8'hFF);
    end
    $display("done: block");
    // Sixty-five bytes into sixty-four places
    dw(`RFL_A_S_RXR, 8'h00);
    dw(`RFL_A_RXLEN, 8'h41);
    dw(`RFL_A_S_RX, 8'h00);
    @(posedge ref_clk);
    for (int i = 0; i < 65; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= 8'(i);
      rx_crc_ok <= i[0];
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    drd(`RFL_A_STAT);
    chk("overflow", 8'h0A, b);
    drd(`RFL_A_FIFO);
    chk("rx byte", 8'h00, b);
    dw(`RFL_A_STAT, 8'hFF);
    dw(`RFL_A_RXLEN, 8'h01);
    dw(`RFL_A_ARK, 8'h01);
    dw(`RFL_A_S_RX, 8'h00);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_crc_ok <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    drd(`RFL_A_STAT);
    chk("ack", 8'h62, b);
    $display("done: receive");
    end_of_test();
  end
endmodule
